/* File: emfsr_top.sv */
// eye monitor fast sweep engine, result fifo and smbus register slave
// assumes smbus pins from outside the clk domain, comparator samples on clk
`timescale 1ns/100ps
`include "emfsr_consts.svh"

module emfsr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = `EMFSR_FIFO_DEPTH
) (
    input  wire logic             clk,      // core clock
    input  wire logic             sys_rst,  // async reset
    input  wire logic             clr,      // flush contents
    input  wire logic             in_valid, // write request
    output logic                  in_ready, // room available
    input  wire logic [WIDTH-1:0] in_data,  // write word
    output logic                  out_valid,// word available
    input  wire logic             out_ready,// read request
    output logic [WIDTH-1:0]      out_data  // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    logic [AW:0]      wp_nxt;
    logic [AW:0]      rp_nxt;

    assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
    assign out_valid = wp_r != rp_r;
    assign out_data  = mem[rp_r[AW-1:0]];

    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (clr) begin
            wp_nxt = '0;
            rp_nxt = '0;
        end else begin
            if (in_valid && in_ready) begin
                wp_nxt = wp_r + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp_nxt = rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && in_ready && !clr) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module emfsr_top #(
    parameter logic [6:0] DEV_ADDR = 7'h18,  // arbitrary bus address
    parameter int POINTS     = `EMFSR_GRID_POINTS,
    parameter int FIFO_DEPTH = `EMFSR_FIFO_DEPTH
) (
    input  wire logic       clk,           // core clock, 40 MHz
    input  wire logic       sys_rst,       // async reset
    input  wire logic       smb_scl,       // smbus clock pin
    input  wire logic       smb_sda_in,    // smbus data pin level
    output logic            smb_sda_out,   // smbus data drive value
    output logic            smb_sda_oe,    // smbus data pull low
    input  wire logic       sample_valid,  // one comparator sample
    input  wire logic       primary_bit,   // primary comparator decision
    input  wire logic       offset_bit,    // offset comparator decision
    input  wire logic [1:0] cdr_range,     // range chosen by cdr
    input  wire logic       cdr_eye_power, // cdr powers monitor for lock check
    output logic [5:0]      phase_offset,  // current phase step
    output logic [5:0]      volt_offset,   // current voltage step
    output logic [1:0]      eye_range,     // applied range code
    output logic            eye_power_on,  // monitor powered
    output logic            eye_override_bit, // override bit
    output logic            lock_check_en, // periodic lock check enable
    output logic [7:0]      channel_sel,   // channel select value
    output logic            sweep_busy     // sweep start bit
);
    localparam logic [12:0] LAST_RD = 13'(POINTS + `EMFSR_INVALID_POINTS - 1);
    localparam logic [12:0] NPTS    = 13'(POINTS);

    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    emfsr_pkg::emfsr_smb_e st_r, st_nxt;
    emfsr_pkg::emfsr_byte_t sh_r, sh_nxt, ptr_r, ptr_nxt, byte_in, rd_byte;
    emfsr_pkg::emfsr_byte_t rng_r, rng_nxt, ovr_r, ovr_nxt, dwell_r, dwell_nxt;
    emfsr_pkg::emfsr_byte_t lck_r, lck_nxt, chs_r, chs_nxt;
    emfsr_pkg::emfsr_count_t cur_r, cur_nxt, err_r, err_nxt, f_data;
    logic [2:0]  cnt_r, cnt_nxt;
    logic [12:0] rdcnt_r, rdcnt_nxt, idx_r, idx_nxt;
    logic [17:0] samp_r, samp_nxt, target;
    logic rw_r, rw_nxt, oe_r, oe_nxt, ack_r, ack_nxt, fen_r, fen_nxt;
    logic busy_r, busy_nxt, rov_r, rov_nxt, lsb_r, lsb_nxt;
    logic wr_en, rd_ld, adv, start_pulse, push, f_in_ready, f_valid, pop;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // two-stage synchronisers, third stage only for edge finding
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {smb_scl, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {smb_sda_in, sda_s1, sda_s2};
        end
    end
    assign scl_rise  = scl_s2 && !scl_s3;
    assign scl_fall  = !scl_s2 && scl_s3;
    assign bus_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign bus_stop  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
    assign byte_in   = {sh_r[6:0], sda_s2};

    // read mux without side effects
    always_comb begin
        case (ptr_r)
            `EMFSR_REG_RANGE_PWR:  rd_byte = rng_r;
            `EMFSR_REG_OVERRIDE:   rd_byte = ovr_r;
            `EMFSR_REG_FAST_SWEEP: rd_byte = {fen_r, 6'h00, busy_r};
            `EMFSR_REG_CNT_HIGH:   rd_byte = lsb_r ? cur_r[7:0] : cur_r[15:8];
            `EMFSR_REG_CNT_LOW:    rd_byte = cur_r[7:0];
            `EMFSR_REG_DWELL:      rd_byte = dwell_r;
            `EMFSR_REG_LOCK_VALID: rd_byte = lck_r;
            `EMFSR_REG_CHAN_SEL:   rd_byte = chs_r;
            default:               rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // smbus slave, registers and readout pairing
    always_comb begin
        st_nxt = st_r;  sh_nxt = sh_r;  cnt_nxt = cnt_r;  rw_nxt = rw_r;
        ptr_nxt = ptr_r;  oe_nxt = oe_r;  ack_nxt = ack_r;
        rng_nxt = rng_r;  ovr_nxt = ovr_r;  fen_nxt = fen_r;  busy_nxt = busy_r;
        dwell_nxt = dwell_r;  lck_nxt = lck_r;  chs_nxt = chs_r;  rov_nxt = rov_r;
        lsb_nxt = lsb_r;  cur_nxt = cur_r;  rdcnt_nxt = rdcnt_r;
        wr_en = 1'b0;  rd_ld = 1'b0;  adv = 1'b0;  start_pulse = 1'b0;
        pop = 1'b0;
        if (bus_stop) begin
            st_nxt = emfsr_pkg::SMB_IDLE;
            oe_nxt = 1'b0;
        end else if (bus_start) begin
            st_nxt  = emfsr_pkg::SMB_ADDR;
            cnt_nxt = 3'h0;
            oe_nxt  = 1'b0;
        end else begin
            case (st_r)
                emfsr_pkg::SMB_ADDR, emfsr_pkg::SMB_PTR, emfsr_pkg::SMB_WDATA: begin
                    if (scl_rise) begin
                        sh_nxt  = byte_in;
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == 3'h7) begin
                            if (st_r == emfsr_pkg::SMB_ADDR) begin
                                st_nxt = (byte_in[7:1] == DEV_ADDR) ?
                                         emfsr_pkg::SMB_ADDR_ACK : emfsr_pkg::SMB_IDLE;
                                rw_nxt = byte_in[0];
                            end else if (st_r == emfsr_pkg::SMB_PTR) begin
                                ptr_nxt = byte_in;
                                st_nxt  = emfsr_pkg::SMB_PTR_ACK;
                            end else begin
                                wr_en  = 1'b1;
                                st_nxt = emfsr_pkg::SMB_WDATA_ACK;
                            end
                        end
                    end
                end
                emfsr_pkg::SMB_ADDR_ACK, emfsr_pkg::SMB_PTR_ACK,
                emfsr_pkg::SMB_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_nxt = !oe_r;
                        if (oe_r) begin
                            cnt_nxt = 3'h0;
                            if (st_r == emfsr_pkg::SMB_ADDR_ACK && rw_r) begin
                                rd_ld = 1'b1;
                            end else if (st_r == emfsr_pkg::SMB_ADDR_ACK) begin
                                st_nxt = emfsr_pkg::SMB_PTR;
                            end else begin
                                st_nxt = emfsr_pkg::SMB_WDATA;
                            end
                        end
                    end
                end
                emfsr_pkg::SMB_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_r == 3'h7) begin
                            oe_nxt  = 1'b0;
                            cnt_nxt = 3'h0;
                            st_nxt  = emfsr_pkg::SMB_RDATA_ACK;
                        end else begin
                            sh_nxt  = {sh_r[6:0], 1'b0};
                            oe_nxt  = !sh_r[6];
                            cnt_nxt = cnt_r + 3'h1;
                        end
                    end
                end
                emfsr_pkg::SMB_RDATA_ACK: begin
                    if (scl_rise) begin
                        ack_nxt = !sda_s2;
                        cnt_nxt = 3'h1;
                    end else if (scl_fall && cnt_r == 3'h1) begin
                        if (ack_r) begin
                            rd_ld = 1'b1;
                        end else begin
                            st_nxt = emfsr_pkg::SMB_IDLE;
                        end
                    end
                end
                default: st_nxt = emfsr_pkg::SMB_IDLE;
            endcase
        end
        if (rd_ld) begin
            st_nxt  = emfsr_pkg::SMB_RDATA;
            sh_nxt  = rd_byte;
            oe_nxt  = !rd_byte[7];
            cnt_nxt = 3'h0;
            if (ptr_r != `EMFSR_REG_CNT_HIGH) begin
                ptr_nxt = ptr_r + 8'h01;
            end
            if (ptr_r == `EMFSR_REG_CNT_HIGH) begin
                lsb_nxt = !lsb_r;
                adv     = lsb_r;
            end else if (ptr_r == `EMFSR_REG_CNT_LOW) begin
                lsb_nxt = 1'b0;
                adv     = lsb_r;
            end
        end
        // load next point after both bytes
        if (adv) begin
            rdcnt_nxt = rdcnt_r + 13'h0001;
            // leading pairs carry no point, so the fifo head is kept for later
            if (rdcnt_r != 13'h0000 && rdcnt_r != LAST_RD) begin
                pop     = f_valid;
                cur_nxt = f_valid ? f_data : cur_r;
            end
            if (rdcnt_r == LAST_RD) begin
                busy_nxt = 1'b0;
            end
        end
        if (wr_en) begin
            ptr_nxt = ptr_r + 8'h01;
            case (ptr_r)
                `EMFSR_REG_RANGE_PWR: begin
                    rng_nxt = byte_in;
                    rov_nxt = 1'b1;
                end
                `EMFSR_REG_OVERRIDE:   ovr_nxt = byte_in;
                `EMFSR_REG_DWELL:      dwell_nxt = byte_in;
                `EMFSR_REG_LOCK_VALID: lck_nxt = byte_in;
                `EMFSR_REG_CHAN_SEL:   chs_nxt = byte_in;
                `EMFSR_REG_FAST_SWEEP: begin
                    fen_nxt = byte_in[`EMFSR_BIT_SWEEP_EN];
                    if (byte_in[`EMFSR_BIT_SWEEP_EN] && byte_in[`EMFSR_BIT_SWEEP_START]) begin
                        busy_nxt    = 1'b1;
                        start_pulse = 1'b1;
                        lsb_nxt     = 1'b0;
                        cur_nxt     = 16'h0000;
                        rdcnt_nxt   = 13'h0000;
                    end else if (!byte_in[`EMFSR_BIT_SWEEP_EN]) begin
                        busy_nxt = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= emfsr_pkg::SMB_IDLE;  sh_r <= 8'h00;  cnt_r <= 3'h0;
            rw_r <= 1'b0;  ptr_r <= 8'h00;  oe_r <= 1'b0;  ack_r <= 1'b0;
            rng_r <= `EMFSR_RANGE_PWR_RST;
            ovr_r <= `EMFSR_OVERRIDE_RST;  dwell_r <= `EMFSR_DWELL_RST;
            lck_r <= `EMFSR_LOCK_VALID_RST;  chs_r <= `EMFSR_CHAN_SEL_RST;
            fen_r <= 1'b0;  busy_r <= 1'b0;  rov_r <= 1'b0;  lsb_r <= 1'b0;
            cur_r <= 16'h0000;  rdcnt_r <= 13'h0000;
        end else begin
            st_r <= st_nxt;  sh_r <= sh_nxt;  cnt_r <= cnt_nxt;
            rw_r <= rw_nxt;  ptr_r <= ptr_nxt;  oe_r <= oe_nxt;  ack_r <= ack_nxt;
            rng_r <= rng_nxt;  ovr_r <= ovr_nxt;  dwell_r <= dwell_nxt;
            lck_r <= lck_nxt;  chs_r <= chs_nxt;
            fen_r <= fen_nxt;  busy_r <= busy_nxt;  rov_r <= rov_nxt;  lsb_r <= lsb_nxt;
            cur_r <= cur_nxt;  rdcnt_r <= rdcnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sweep engine: counts disagreements, runs ahead of the reader
    assign target = {dwell_r, `EMFSR_DWELL_LSBS};

    always_comb begin
        idx_nxt  = idx_r;
        samp_nxt = samp_r;
        err_nxt  = err_r;
        push     = 1'b0;
        if (start_pulse) begin
            idx_nxt  = 13'h0000;
            samp_nxt = 18'h00000;
            err_nxt  = 16'h0000;
        end else if (busy_r && idx_r != NPTS) begin
            if (samp_r == target) begin
                push = 1'b1;
                if (f_in_ready) begin
                    idx_nxt  = idx_r + 13'h0001;
                    samp_nxt = 18'h00000;
                    err_nxt  = 16'h0000;
                end
            end else if (sample_valid) begin
                samp_nxt = samp_r + 18'h00001;
                if (primary_bit != offset_bit && err_r != 16'hFFFF) begin
                    err_nxt = err_r + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idx_r  <= 13'h0000;
            samp_r <= 18'h00000;
            err_r  <= 16'h0000;
        end else begin
            idx_r  <= idx_nxt;
            samp_r <= samp_nxt;
            err_r  <= err_nxt;
        end
    end

    emfsr_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clr       (start_pulse),
        .in_valid  (push),
        .in_ready  (f_in_ready),
        .in_data   (err_r),
        .out_valid (f_valid),
        .out_ready (pop),
        .out_data  (f_data)
    );

    assign phase_offset     = idx_r[5:0];
    assign volt_offset      = idx_r[11:6];
    assign eye_range        = rov_r ? rng_r[7:6] : cdr_range;
    assign eye_power_on     = !rng_r[`EMFSR_BIT_PWR_DOWN] || cdr_eye_power;
    assign eye_override_bit = ovr_r[`EMFSR_BIT_OVERRIDE];
    assign lock_check_en    = lck_r[`EMFSR_BIT_LOCK_CHECK];
    assign channel_sel      = chs_r;
    assign sweep_busy       = busy_r;
    assign smb_sda_out      = 1'b0;
    assign smb_sda_oe       = oe_r;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_hi_read;
        rd_ld && ptr_r == `EMFSR_REG_CNT_HIGH && !lsb_r;
    endsequence
    sequence s_lo_via_high;
        rd_ld && ptr_r == `EMFSR_REG_CNT_HIGH && lsb_r;
    endsequence

    a_start_sets_busy: assert property (start_pulse |=> busy_r && idx_r == 13'h0000)
        else $error("start write did not begin sweep");
    a_point_step: assert property (
        push && f_in_ready |=> idx_r == $past(idx_r) + 13'h0001 && samp_r == 18'h00000)
        else $error("sweep did not step after a point");
    a_dwell_len: assert property (push |-> samp_r == {dwell_r, 10'h3FF})
        else $error("point ended at wrong sample count");
    a_high_low_pair: assert property (
        s_hi_read |=> lsb_r && sh_r == $past(cur_r[15:8]) ##0 (!rd_ld)[*1])
        else $error("high byte not followed by low byte");
    a_no_early_load: assert property (s_hi_read |=> cur_r == $past(cur_r))
        else $error("next point loaded before low byte");
    a_low_value: assert property (
        s_lo_via_high |=> sh_r == $past(cur_r[7:0]) && !lsb_r)
        else $error("low byte value wrong");
    a_done_clear: assert property (adv && rdcnt_r == LAST_RD |=> !busy_r)
        else $error("start bit not cleared after sweep");
    a_data_ready: assert property (
        busy_r && adv && rdcnt_r != 13'h0000 && rdcnt_r != LAST_RD |-> f_valid)
        else $error("point read before it was measured");
    a_resume_ptr: assert property (
        rd_ld && ptr_r == `EMFSR_REG_CNT_HIGH |=> ptr_r == `EMFSR_REG_CNT_HIGH)
        else $error("pointer moved off count-high");
    a_power_force: assert property (!rng_r[5] |-> eye_power_on)
        else $error("monitor not powered with power-down clear");
    a_range_src: assert property (eye_range == (rov_r ? rng_r[7:6] : cdr_range))
        else $error("range source wrong");
endmodule

/* File: emfsr_consts.svh */
// register offsets, field positions, reset values and counts of the eye monitor readout
// assumes inclusion by bare name from the design file
`ifndef EMFSR_CONSTS_SVH
`define EMFSR_CONSTS_SVH

`define EMFSR_REG_RANGE_PWR   8'h11
`define EMFSR_REG_OVERRIDE    8'h22
`define EMFSR_REG_FAST_SWEEP  8'h24
`define EMFSR_REG_CNT_HIGH    8'h25
`define EMFSR_REG_CNT_LOW     8'h26
`define EMFSR_REG_DWELL       8'h2A
`define EMFSR_REG_LOCK_VALID  8'h3E
`define EMFSR_REG_CHAN_SEL    8'hFF

`define EMFSR_BIT_SWEEP_EN    7
`define EMFSR_BIT_SWEEP_START 0
`define EMFSR_BIT_PWR_DOWN    5
`define EMFSR_BIT_OVERRIDE    7
`define EMFSR_BIT_LOCK_CHECK  7

`define EMFSR_RANGE_PWR_RST   8'h20
`define EMFSR_OVERRIDE_RST    8'h00
`define EMFSR_FAST_SWEEP_RST  8'h00
`define EMFSR_DWELL_RST       8'h00
`define EMFSR_LOCK_VALID_RST  8'h80
`define EMFSR_CHAN_SEL_RST    8'h00

`define EMFSR_GRID_POINTS     4096
`define EMFSR_INVALID_POINTS  2
`define EMFSR_DWELL_LSBS      10'h3FF
`define EMFSR_FIFO_DEPTH      32

`endif

/* File: emfsr_pkg.sv */
// types shared by the eye monitor fast sweep readout
// assumes nothing of its surroundings
package emfsr_pkg;
    typedef enum logic [3:0] {
        SMB_IDLE,
        SMB_ADDR,
        SMB_ADDR_ACK,
        SMB_PTR,
        SMB_PTR_ACK,
        SMB_WDATA,
        SMB_WDATA_ACK,
        SMB_RDATA,
        SMB_RDATA_ACK
    } emfsr_smb_e;
    typedef logic [7:0]  emfsr_byte_t;
    typedef logic [15:0] emfsr_count_t;
endpackage

/* File: emfsr_smb_master.sv */
// smbus controller model that sets up and reads the eye monitor readout
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/100ps
module emfsr_smb_master (
    input  wire logic clk,   // core clock
    input  wire logic sda,   // resolved data line
    output logic      scl,   // bus clock, idle high
    output logic      sda_oe // high pulls data low
);
    logic [6:0] addr;
    logic       nak;
    logic [7:0] q[$];
    initial begin
        addr = 7'h18;
        nak = 1'b0;
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // half bus period of 4 core cycles
    task automatic hp();
        repeat (4) @(negedge clk);
    endtask
    task automatic bx(input logic b, output logic r);
        sda_oe = !b;
        hp();
        scl = 1'b1;
        hp();
        r = sda;
        scl = 1'b0;
    endtask
    // s high gives start, low gives stop
    task automatic sr(input logic s);
        sda_oe = !s;
        hp();
        scl = 1'b1;
        hp();
        sda_oe = s;
        hp();
        scl = !s;
    endtask
    task automatic xb(input logic [7:0] d, input logic ak, input logic ck, output logic [7:0] r);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bx(d[i], r[i]);
        end
        bx(ak, b);
        if (ck)
            nak = nak | b;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] r;
        sr(1'b1);
        xb({addr, 1'b0}, 1'b1, 1'b1, r);
        xb(p, 1'b1, 1'b1, r);
        xb(d, 1'b1, 1'b1, r);
        sr(1'b0);
    endtask
    // readout resumes
    // every call addresses the device anew, so a long readout can be split
    task automatic rd(input logic [7:0] p, input int n);
        logic [7:0] r;
        sr(1'b1);
        xb({addr, 1'b0}, 1'b1, 1'b1, r);
        xb(p, 1'b1, 1'b1, r);
        sr(1'b1);
        xb({addr, 1'b1}, 1'b1, 1'b1, r);
        for (int i = 0; i < n; i++) begin
            xb(8'hFF, i == n - 1, 1'b0, r);
            q.push_back(r);
        end
        sr(1'b0);
    endtask
endmodule

/* File: tb_emfsr_top.sv */
// self-checking bench of the eye monitor fast sweep readout
// assumes the design files and the smbus controller model compiled first
`timescale 1ns/100ps
module tb_emfsr_top;
    localparam int PTS = 34;
    localparam int NP  = 1030;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cpw = 1'b0;
    logic [1:0]  crng = 2'h2;
    logic        scl, m_oe, u_out, u_oe, sda, pwr, ovr, lck, busy;
    logic        obit = 1'b0;
    logic [5:0]  pofs, vofs;
    logic [1:0]  rng;
    logic [7:0]  chan;
    int          fail_count = 0;
    int          samples_checked = 0;
    logic [23:0] rows [12] = '{24'h116060, 24'h118080, 24'h110000, 24'h11C0C0,
        24'h228080, 24'h220000, 24'h3E0000, 24'hFF0505, 24'h2A0101,
        24'h248280, 24'h240100, 24'h305A00};
    assign sda = !m_oe && !(u_oe && !u_out);
    always #12.5 clk = ~clk;
    // offset decision follows the phase step: even points all errors, odd points none
    always @(negedge clk) obit <= pofs[0];
    emfsr_smb_master m (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
    emfsr_top #(.POINTS(PTS)) uut (
        .clk(clk), .sys_rst(sys_rst), .smb_scl(scl), .smb_sda_in(sda),
        .smb_sda_out(u_out), .smb_sda_oe(u_oe), .sample_valid(1'b1),
        .primary_bit(1'b1), .offset_bit(obit), .cdr_range(crng),
        .cdr_eye_power(cpw), .phase_offset(pofs), .volt_offset(vofs), .eye_range(rng),
        .eye_power_on(pwr), .eye_override_bit(ovr), .lock_check_en(lck),
        .channel_sel(chan), .sweep_busy(busy));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        samples_checked++;
        if (a !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, a, e);
        end
    endtask
    task automatic pair(input logic [15:0] e);
        logic [15:0] v;
        v[15:8] = m.q.pop_front();
        v[7:0] = m.q.pop_front();
        chk(v, e);
    endtask
    task automatic rst_chk();
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(16'({lck, busy, ovr, chan}), 16'h0400);
        chk(16'({pwr, rng}), 16'({cpw, crng}));
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (99000) @(posedge clk);
        fail_count++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [23:0] r;
        rst_chk();
        m.addr = 7'h19;
        m.wr(8'hFF, 8'h07);
        chk(16'({m.nak, chan}), 16'h0100);
        m.addr = 7'h18;
        m.nak = 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            m.wr(r[23:16], r[15:8]);
            m.rd(r[23:16], 1);
            chk(16'(m.q.pop_front()), 16'(r[7:0]));
            case (r[23:16])
                8'h11: chk(16'({pwr, rng}), 16'({!r[13], r[15:14]}));
                8'h22: chk(16'(ovr), 16'(r[15]));
                8'h3E: chk(16'(lck), 16'(r[15]));
                8'hFF: chk(16'(chan), 16'(r[15:8]));
                8'h24: chk(16'(busy), 16'h0000);
                default: ;
            endcase
        end
        chk(16'(m.nak), 16'h0000);
        m.wr(8'h24, 8'h81);
        chk(16'(busy), 16'h0001);
        repeat (6 * NP) @(negedge clk);
        repeat (3) begin
            m.rd(8'h25, 1);
            m.rd(8'h26, 1);
        end
        m.q = m.q[4:$];
        pair(16'h07FF);
        m.rd(8'h24, 1);
        chk(16'(m.q.pop_front()), 16'h0081);
        m.wr(8'h24, 8'h00);
        chk(16'(busy), 16'h0000);
        m.wr(8'h2A, 8'h00);
        m.wr(8'h24, 8'h81);
        repeat (32 * NP) @(negedge clk);
        m.rd(8'h25, 40);
        repeat (5 * NP) @(negedge clk);
        chk(16'(busy), 16'h0001);
        m.rd(8'h25, 2 * PTS - 36);
        chk(16'(busy), 16'h0000);
        chk(16'({vofs, pofs}), 16'(PTS));
        m.q = m.q[4:$];
        for (int k = 0; k < PTS; k++) begin
            pair(k[0] ? 16'h0000 : 16'h03FF);
        end
        m.wr(8'h24, 8'h00);
        m.wr(8'h11, 8'h20);
        chk(16'(pwr), 16'h0000);
        m.wr(8'h3E, 8'h80);
        chk(16'(lck), 16'h0001);
        cpw = 1'b1;
        crng = 2'h1;
        rst_chk();
        complete_run();
    end
endmodule
